/* File: testbench/ovh_source.sv */
`timescale 1ns/1ps
module ovh_source
  import tpom_pkg::*;
(
  input wire logic i_clk,
  output ovh_sample_t o_ovh
);
  initial o_ovh = '0;
  // Between frames fields carry inverted junk so stale values are never trusted
  task automatic send(input logic [7:0] v5, input logic [7:0] z7, input logic [3:0] rei,
    input logic [7:0] bip, input int n);
    repeat (n)
    begin
      @(posedge i_clk);
      o_ovh <= '{1'b1, v5, z7, v5, rei, bip};
    end
    @(posedge i_clk);
    o_ovh <= '{1'b0, ~v5, ~z7, ~v5, ~rei, ~bip};
  endtask
endmodule // ovh_source

/* File: testbench/testbench.sv */
`timescale 1ns/1ps
module testbench
  import tpom_pkg::*;
;
  logic i_clk = 1'b0;
  logic i_srst = 1'b1;
  reg_req_t req = '0;
  alarm_in_t alarm = '0;
  ovh_sample_t ovh;
  logic [7:0] rd_data;
  logic irq;
  logic pdo;
  logic ais;
  trib_type_t ttype;
  logic [2:0] active;
  int err_count = 0;
  int compares = 0;
  int irq_n = 0;
  always #20 i_clk = ~i_clk;
  always @(posedge i_clk)
    if (irq === 1'b1)
      irq_n <= irq_n + 1;
  ovh_source u_src (.i_clk(i_clk), .o_ovh(ovh));
  // Second TUG2, so the group interrupt enables must go dead in TU3 mode
  tributary_path_overhead_monitor #(.TUG2_INDEX(2)) dut (.i_clk(i_clk), .i_srst(i_srst), .i_req(req), .i_ovh(ovh),
    .i_alarm(alarm), .o_rd_data(rd_data), .o_irq(irq), .o_payload_defect_output(pdo), .o_ais_insert(ais),
    .o_trib_type(ttype), .o_active_tributaries(active));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp)
    begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    @(posedge i_clk);
    req <= '{a, d, 1'b1, 1'b0};
    @(posedge i_clk);
    req <= '0;
  endtask
  task automatic rd(input logic [9:0] a, input logic [7:0] exp);
    @(posedge i_clk);
    req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge i_clk);
    req <= '0;
    #1;
    chk(rd_data, exp);
  endtask
  task automatic settle;
    repeat (3) @(posedge i_clk);
    #1;
  endtask
  task automatic frames(input logic [7:0] v5, input logic [7:0] z7, input int n, input logic [7:0] exp);
    u_src.send(v5, z7, 4'h0, 8'h00, n);
    settle;
    rd(OFS_CFG_ALARM, exp);
  endtask
  task automatic wrap_up;
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial
  begin
    int n;
    repeat (6) @(posedge i_clk);
    i_srst <= 1'b0;
    rd(OFS_GROUP_CFG, GROUP_CFG_RESET);
    rd(OFS_CFG_ALARM, 8'h00);
    rd(10'h3FF, 8'h00);
    for (int t = 0; t < 4; t++)
    begin
      wr(OFS_GROUP_CFG, 8'(t * 64));
      settle;
      chk(8'(ttype), 8'(t));
      chk(8'(active), 8'(t + 1));
    end
    // 2100 errors overflow the 11-bit view outside tu3
    u_src.send(8'h20, 8'h00, 4'h0, 8'h00, 2100);
    wr(OFS_ACCUM_TRIG, 8'h00);
    rd(OFS_REI_LOW, 8'h34);
    rd(OFS_REI_HIGH, 8'h00);
    for (int b = 0; b < 2; b++)
    begin
      wr(OFS_GROUP_CFG, 8'(192 + b * 32));
      u_src.send(8'h20, 8'h00, 4'h0, 8'h03, 2);
      u_src.send(8'h20, 8'h00, 4'h0, 8'h01, 1);
      wr(OFS_ACCUM_TRIG, 8'h00);
      rd(OFS_REI_LOW, 8'h03);
      rd(OFS_BIP_LOW, b ? 8'h03 : 8'h05);
    end
    wr(OFS_MON_CTRL, 8'h01);
    u_src.send(8'h00, 8'h00, 4'h8, 8'h00, 300);
    wr(OFS_ACCUM_TRIG, 8'h00);
    rd(OFS_REI_LOW, 8'h60);
    rd(OFS_REI_HIGH, 8'h09);
    // Mismatch toggles with its enable set, yet TU3 keeps it silent
    n = irq_n;
    wr(OFS_GROUP_CFG, 8'hC8);
    wr(OFS_EXP_LABEL, 8'h01);
    settle;
    rd(OFS_CFG_ALARM, 8'h08);
    wr(OFS_EXP_LABEL, 8'h00);
    settle;
    chk(8'(irq_n - n), 8'h00);
    wr(OFS_MON_CTRL, 8'h00);
    wr(OFS_GROUP_CFG, 8'hC1);
    n = irq_n;
    frames(8'h01, 8'h00, 4, 8'h00);
    frames(8'h01, 8'h00, 1, 8'h01);
    chk(8'(irq_n - n), 8'h01);
    wr(OFS_MON_CTRL, 8'h02);
    frames(8'h00, 8'h00, 9, 8'h01);
    frames(8'h00, 8'h00, 1, 8'h00);
    chk(8'(irq_n - n), 8'h02);
    wr(OFS_GROUP_CFG, 8'hC2);
    wr(OFS_CFG_ALARM, 8'h80);
    frames(8'h00, 8'h0A, 10, 8'h85);
    wr(OFS_CFG_ALARM, 8'h00);
    frames(8'h10, 8'h00, 10, 8'h02);
    chk(8'(irq_n - n), 8'h03);
    wr(OFS_GROUP_CFG, 8'hDC);
    wr(OFS_MON_CTRL, 8'h0C);
    n = irq_n;
    frames(8'h06, 8'h00, 4, 8'h02);
    rd(OFS_ACC_LABEL, 8'h00);
    frames(8'h06, 8'h00, 1, 8'h08);
    rd(OFS_ACC_LABEL, 8'h03);
    chk(8'(pdo), 8'h01);
    chk(8'(irq_n - n), 8'h01);
    for (int i = 0; i < 2; i++)
    begin
      u_src.send(8'h02, 8'h00, 4'h0, 8'h00, 1);
      u_src.send(8'h04, 8'h00, 4'h0, 8'h00, 1);
    end
    frames(8'h02, 8'h00, 1, 8'h18);
    chk(8'(pdo), 8'h00);
    frames(8'h06, 8'h00, 5, 8'h08);
    chk(8'(pdo), 8'h01);
    chk(8'(irq_n - n), 8'h03);
    wr(OFS_EXP_LABEL, 8'h03);
    settle;
    rd(OFS_CFG_ALARM, 8'h00);
    chk(8'(irq_n - n), 8'h04);
    frames(8'h00, 8'h00, 5, 8'h08);
    chk(8'(pdo), 8'h00);
    chk(8'(irq_n - n), 8'h05);
    wr(OFS_CFG_ALARM, 8'h20);
    settle;
    chk(8'(pdo), 8'h01);
    @(posedge i_clk);
    alarm <= '{1'b1, 1'b0, 1'b1};
    settle;
    chk(8'(ais), 8'h01);
    wr(OFS_CFG_ALARM, 8'h40);
    alarm <= '{1'b0, 1'b0, 1'b1};
    settle;
    chk(8'(ais), 8'h01);
    wr(OFS_CFG_ALARM, 8'h00);
    settle;
    chk(8'(ais), 8'h00);
    wrap_up;
  end
endmodule // testbench

/* File: testbench/tpom_checker.sv */
`timescale 1ns/1ps
module tpom_checker
  import tpom_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_srst,
  input wire reg_req_t i_req,
  input wire ovh_sample_t i_ovh,
  input wire alarm_in_t i_alarm,
  input wire logic [DATA_W-1:0] o_rd_data,
  input wire logic o_irq,
  input wire logic o_payload_defect_output,
  input wire logic o_ais_insert,
  input wire trib_type_t o_trib_type,
  input wire logic [2:0] o_active_tributaries
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_srst);
  logic [7:0] cfg;
  logic [2:0] ca;
  logic tu3_seen;
  logic [1:0] quiet_n;
  logic [1:0] force_n;
  logic [1:0] mask_n;
  logic [2:0] act_n;
  // Saturating settle counts leave the design two cycles of pipeline
  function automatic logic [1:0] bump(input logic c, input logic [1:0] n);
    return c ? ((n == 2'h3) ? n : n + 2'h1) : 2'h0;
  endfunction
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      cfg <= GROUP_CFG_RESET;
      ca <= 3'h0;
      tu3_seen <= 1'b0;
      quiet_n <= 2'h0;
      force_n <= 2'h0;
      mask_n <= 2'h0;
      act_n <= 3'h0;
    end
    else
    begin
      if (i_req.wr && i_req.addr == OFS_GROUP_CFG)
        cfg <= i_req.wdata;
      if (i_req.wr && i_req.addr == OFS_CFG_ALARM)
        ca <= i_req.wdata[7:5];
      if (i_req.wr && i_req.addr == OFS_MON_CTRL && i_req.wdata[MC_TU3])
        tu3_seen <= 1'b1;
      quiet_n <= bump(!ca[1] && !i_alarm.lop && !i_alarm.lom, quiet_n);
      force_n <= bump(ca[0], force_n);
      mask_n <= bump(cfg[4:0] == 5'h00, mask_n);
      act_n <= (i_ovh.mf_valid || i_req.wr) ? 3'h0 : ((act_n == 3'h7) ? act_n : act_n + 3'h1);
    end
  end
  property p_active_count;
    o_active_tributaries == 3'(o_trib_type) + 3'h1;
  endproperty
  a_active_count: assert property (p_active_count) else $error("active count disagrees with type");
  property p_type_cfg;
    cfg == $past(cfg) |-> 2'(o_trib_type) == cfg[7:6];
  endproperty
  a_type_cfg: assert property (p_type_cfg) else $error("type output differs from field");
  property p_force_pdo;
    force_n == 2'h3 |-> o_payload_defect_output;
  endproperty
  a_force_pdo: assert property (p_force_pdo) else $error("forced payload defect is low");
  property p_quiet_ais;
    quiet_n == 2'h3 |-> !o_ais_insert;
  endproperty
  a_quiet_ais: assert property (p_quiet_ais) else $error("through path inserts without alarm");
  property p_mask_irq;
    mask_n == 2'h3 |-> !o_irq;
  endproperty
  a_mask_irq: assert property (p_mask_irq) else $error("interrupt with all enables low");
  property p_high_zero;
    !tu3_seen && i_req.rd && (i_req.addr == OFS_REI_HIGH || i_req.addr == OFS_BIP_HIGH) |=> o_rd_data[7:3] == 5'h00;
  endproperty
  a_high_zero: assert property (p_high_zero) else $error("upper count bits set outside tu3");
  property p_rd_idle;
    !$past(i_req.rd) |-> o_rd_data == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside answer cycle");
  property p_irq_cause;
    o_irq |-> act_n <= 3'h4;
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("interrupt with no recent cause");
  c_irq: cover property (o_irq);
  c_pdo: cover property ($rose(o_payload_defect_output));
  c_ais: cover property (o_ais_insert);
endmodule // tpom_checker

bind tributary_path_overhead_monitor tpom_checker u_chk (.i_clk(i_clk), .i_srst(i_srst), .i_req(i_req),
  .i_ovh(i_ovh), .i_alarm(i_alarm), .o_rd_data(o_rd_data), .o_irq(o_irq),
  .o_payload_defect_output(o_payload_defect_output), .o_ais_insert(o_ais_insert),
  .o_trib_type(o_trib_type), .o_active_tributaries(o_active_tributaries));

/* File: verilog/persist_filter.sv */
`timescale 1ns/1ps
module persist_filter
  import tpom_pkg::*;
#(
  parameter int W = 1
)
(
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_sample,
  input wire logic [W-1:0] i_value,
  input wire logic [3:0] i_run_len,
  output logic [W-1:0] o_value
);

  typedef struct packed {
    logic [W-1:0] cand;
    logic [3:0] run;
    logic [W-1:0] value;
  } filt_state_t;

  filt_state_t st;
  filt_state_t next_st;

  initial
  begin
    if (W < 1)
      $error("persist_filter: W must be at least 1");
  end

  always_comb
  begin
    next_st = st;
    if (i_sample)
    begin
      if (i_value == st.cand)
      begin
        if (st.run != 4'hF)
          next_st.run = st.run + 4'h1;
      end
      else
      begin
        next_st.cand = i_value;
        next_st.run = 4'h1;
      end
      // A run longer than needed keeps the value; only a new run moves it
      if (next_st.run >= i_run_len)
        next_st.value = next_st.cand;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_srst)
      st <= '0;
    else
      st <= next_st;
  end

  assign o_value = st.value;

endmodule // persist_filter

/* File: verilog/tpom_pkg.sv */
package tpom_pkg;

  localparam int ADDR_W = 10;
  localparam int DATA_W = 8;

  localparam logic [ADDR_W-1:0] OFS_BIP_LOW = 10'h104;
  localparam logic [ADDR_W-1:0] OFS_BIP_HIGH = 10'h105;
  localparam logic [ADDR_W-1:0] OFS_REI_LOW = 10'h106;
  localparam logic [ADDR_W-1:0] OFS_REI_HIGH = 10'h107;
  localparam logic [ADDR_W-1:0] OFS_GROUP_CFG = 10'h108;
  localparam logic [ADDR_W-1:0] OFS_CFG_ALARM = 10'h109;
  localparam logic [ADDR_W-1:0] OFS_MON_CTRL = 10'h140;
  localparam logic [ADDR_W-1:0] OFS_EXP_LABEL = 10'h141;
  localparam logic [ADDR_W-1:0] OFS_ACC_LABEL = 10'h142;
  localparam logic [ADDR_W-1:0] OFS_ACCUM_TRIG = 10'h143;

  // tributary_group_config fields
  localparam int GC_REMOTE_DEFECT_IE = 0;
  localparam int GC_REMOTE_FAILURE_IE = 1;
  localparam int GC_LABEL_CHANGE_IE = 2;
  localparam int GC_LABEL_MISMATCH_IE = 3;
  localparam int GC_LABEL_UNSTABLE_IE = 4;
  localparam int GC_BLOCK_PARITY = 5;
  localparam int GC_TYPE_LSB = 6;
  localparam logic [7:0] GROUP_CFG_RESET = 8'hC0;

  // tributary_config_alarm_status writable fields
  localparam int CA_PAYLOAD_FORCE = 5;
  localparam int CA_TERMINATE = 6;
  localparam int CA_EXT_SELECT = 7;
  localparam logic [2:0] CFG_ALARM_RESET = 3'h0;

  // monitor_control fields
  localparam int MC_TU3 = 0;
  localparam int MC_TEN_FRAME = 1;
  localparam int MC_PD_CODE_LSB = 2;
  localparam logic [7:0] MON_CTRL_RESET = 8'h00;

  // V5 / Z7 bit positions, SONET bit n at index 8-n
  localparam int V5_RDI = 0;
  localparam int V5_LABEL_LSB = 1;
  localparam int V5_RFI = 4;
  localparam int V5_REI = 5;
  localparam int Z7_ERDI_LSB = 1;

  localparam logic [3:0] RUN_SHORT = 4'h5;
  localparam logic [3:0] RUN_LONG = 4'hA;
  localparam logic [3:0] LABEL_RUN = 4'h5;
  localparam logic [2:0] UNSTABLE_LIMIT = 3'h5;

  localparam int CLK_PERIOD_NS = 40;
  localparam int ACCUM_TIME_NS = 10000;
  localparam int ACCUM_MAX_CYCLES = ACCUM_TIME_NS / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    TRIB_TU2,
    TRIB_VT3,
    TRIB_TU12,
    TRIB_TU11
  } trib_type_t;

  typedef struct packed {
    logic mf_valid;
    logic [7:0] v5;
    logic [7:0] z7;
    logic [7:0] tu3_label;
    logic [3:0] tu3_rei;
    logic [7:0] bip_err;
  } ovh_sample_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  typedef struct packed {
    logic lop;
    logic lom;
    logic global_ais;
  } alarm_in_t;

endpackage

/* File: verilog/tributary_path_overhead_monitor.sv */
// Local design decision: strobed register access.
`timescale 1ns/1ps
// Functional notes
// - TU3 mode reports all 16 bits of the remote error count, low and high bytes.
// - Outside TU3 only 11 count bits are meaningful; upper five read zero.
// - Remote errors are counted continuously; readable count covers the last interval.
// - Writing the accumulate trigger copies and restarts the count within 10 us.
// - Interrupt enables and block parity of TUG2 numbers two to seven have no effect in TU3 mode.
// - Remote defect interrupt on every status change when its enable is high.
// - Remote defect from V5 bit 8, or Z7 bits 5 to 7 when selected.
// - Remote failure interrupt on both edges, ignored with Z7 select or TU3.
// - Label change interrupt whenever the accepted label takes a new value.
// - Mismatch interrupt when accepted label starts or stops matching expected label.
// - Unstable interrupt when the label enters or leaves unstable state.
// - Block mode adds one per block with any parity bit wrong.
// - Bit mode adds one for each parity bit in error.
// - Two-bit type field selects TU2, VT3, TU12 or TU11 with 1 to 4 tributaries.
// - Remote defect follows the V5 bit after five or ten equal multiframes.
// - Remote failure follows the V5 bit after five or ten equal multiframes.
// - Extended defect code updates after the same Z7 code persists five or ten.
// - Mismatch status is high while accepted and expected labels differ.
// - Unstable counter counts label changes, clears after five equal multiframes.
// - Unstable status asserts when counter reaches five, negates when cleared.
// - A new label is accepted after five equal consecutive multiframes.
// - Payload defect follows label equal to the defect code for five multiframes.
// - Payload defect force holds the payload defect output high.
// - Terminated paths follow global AIS control; through paths insert on LOP or LOM.
module tributary_path_overhead_monitor
  import tpom_pkg::*;
#(
  parameter int TUG2_INDEX = 1
)
(
  input wire logic i_clk,
  input wire logic i_srst,
  input wire reg_req_t i_req,
  input wire ovh_sample_t i_ovh,
  input wire alarm_in_t i_alarm,
  output logic [DATA_W-1:0] o_rd_data,
  output logic o_irq,
  output logic o_payload_defect_output,
  output logic o_ais_insert,
  output trib_type_t o_trib_type,
  output logic [2:0] o_active_tributaries
);

  typedef struct packed {
    logic [15:0] rei_acc;
    logic [15:0] rei_rd;
    logic [15:0] bip_acc;
    logic [15:0] bip_rd;
    logic [7:0] group_cfg;
    logic [2:0] cfg_alarm;
    logic [7:0] mon_ctrl;
    logic [7:0] exp_label;
    logic [DATA_W-1:0] rd_data;
    logic irq;
    logic [7:0] prev_label;
    logic [2:0] same_run;
    logic [2:0] unstable_cnt;
    logic unstable;
    logic mismatch;
    logic [2:0] prev_defect_view;
    logic prev_rfi;
    logic [7:0] prev_accepted;
    logic pdi;
    logic ais;
    trib_type_t trib_type;
    logic [2:0] active;
  } mon_state_t;

  mon_state_t st;
  mon_state_t next_st;

  logic rdi_f;
  logic rfi_f;
  logic [2:0] erdi_f;
  logic [7:0] accepted_label;
  logic pd_match_f;
  logic tu3;
  logic [3:0] run_len;
  logic [7:0] rx_label;
  logic [7:0] pd_code_ext;

  initial
  begin
    if (TUG2_INDEX < 1 || TUG2_INDEX > 7)
      $error("tributary_path_overhead_monitor: TUG2_INDEX must be 1 to 7");
    if (ACCUM_MAX_CYCLES < 1)
      $error("tributary_path_overhead_monitor: poll latency below one cycle");
  end

  function automatic logic [3:0] ones_count(input logic [7:0] bits);
    logic [3:0] n;
    n = 4'h0;
    for (int i = 0; i < 8; i++)
      n = n + {3'h0, bits[i]};
    return n;
  endfunction

  function automatic trib_type_t decode_type(input logic [1:0] code);
    trib_type_t t;
    case (code)
      2'b00: t = TRIB_TU2;
      2'b01: t = TRIB_VT3;
      2'b10: t = TRIB_TU12;
      2'b11: t = TRIB_TU11;
      default: t = TRIB_TU2;
    endcase
    return t;
  endfunction

  assign tu3 = st.mon_ctrl[MC_TU3];
  assign run_len = st.mon_ctrl[MC_TEN_FRAME] ? RUN_LONG : RUN_SHORT;
  assign rx_label = tu3 ? i_ovh.tu3_label : {5'h00, i_ovh.v5[V5_LABEL_LSB +: 3]};
  assign pd_code_ext = {5'h00, st.mon_ctrl[MC_PD_CODE_LSB +: 3]};

  // Remote defect and failure bits from V5
  persist_filter #(
    .W(1)
  ) u_rdi_filter (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_sample(i_ovh.mf_valid),
    .i_value(i_ovh.v5[V5_RDI]),
    .i_run_len(run_len),
    .o_value(rdi_f)
  );

  persist_filter #(
    .W(1)
  ) u_rfi_filter (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_sample(i_ovh.mf_valid),
    .i_value(i_ovh.v5[V5_RFI]),
    .i_run_len(run_len),
    .o_value(rfi_f)
  );

  persist_filter #(
    .W(3)
  ) u_erdi_filter (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_sample(i_ovh.mf_valid),
    .i_value(i_ovh.z7[Z7_ERDI_LSB +: 3]),
    .i_run_len(run_len),
    .o_value(erdi_f)
  );

  persist_filter #(
    .W(8)
  ) u_label_filter (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_sample(i_ovh.mf_valid),
    .i_value(rx_label),
    .i_run_len(LABEL_RUN),
    .o_value(accepted_label)
  );

  persist_filter #(
    .W(1)
  ) u_pd_filter (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_sample(i_ovh.mf_valid),
    .i_value(rx_label == pd_code_ext),
    .i_run_len(LABEL_RUN),
    .o_value(pd_match_f)
  );

  always_comb
  begin
    logic cfg_live;
    logic ext_sel;
    logic block_mode;
    logic [2:0] defect_view;
    logic [15:0] rei_inc;
    logic [15:0] bip_inc;
    logic poll;
    logic ev_defect;
    logic ev_failure;
    logic ev_change;
    logic ev_mismatch;
    logic ev_unstable;
    logic next_mismatch;
    cfg_live = 1'b0;
    ext_sel = 1'b0;
    block_mode = 1'b0;
    defect_view = 3'h0;
    rei_inc = 16'h0000;
    bip_inc = 16'h0000;
    poll = 1'b0;
    ev_defect = 1'b0;
    ev_failure = 1'b0;
    ev_change = 1'b0;
    ev_mismatch = 1'b0;
    ev_unstable = 1'b0;
    next_mismatch = 1'b0;
    next_st = st;

    // Group interrupt enables and block parity of TUG2 two to seven are dead in TU3 mode
    cfg_live = !(tu3 && TUG2_INDEX > 1);
    ext_sel = st.cfg_alarm[CA_EXT_SELECT - CA_PAYLOAD_FORCE];
    block_mode = cfg_live && st.group_cfg[GC_BLOCK_PARITY] && !tu3;

    // Register writes
    if (i_req.wr)
    begin
      case (i_req.addr)
        OFS_GROUP_CFG: next_st.group_cfg = i_req.wdata;
        OFS_CFG_ALARM: next_st.cfg_alarm = i_req.wdata[CA_EXT_SELECT:CA_PAYLOAD_FORCE];
        OFS_MON_CTRL: next_st.mon_ctrl = i_req.wdata;
        OFS_EXP_LABEL: next_st.exp_label = i_req.wdata;
        OFS_ACCUM_TRIG: poll = 1'b1;
        default: ;
      endcase
    end

    // Error counting; events of the poll cycle start the new interval
    if (i_ovh.mf_valid)
    begin
      rei_inc = tu3 ? {12'h000, i_ovh.tu3_rei} : {15'h0000, i_ovh.v5[V5_REI]};
      if (block_mode)
        bip_inc = {15'h0000, (|i_ovh.bip_err[1:0])};
      else if (tu3)
        bip_inc = {12'h000, ones_count(i_ovh.bip_err)};
      else
        bip_inc = {12'h000, ones_count({6'h00, i_ovh.bip_err[1:0]})};
    end
    if (poll)
    begin
      // Single-cycle transfer, well inside the poll latency budget
      next_st.rei_rd = tu3 ? st.rei_acc : {5'h00, st.rei_acc[10:0]};
      next_st.bip_rd = tu3 ? st.bip_acc : {5'h00, st.bip_acc[10:0]};
      next_st.rei_acc = rei_inc;
      next_st.bip_acc = bip_inc;
    end
    else
    begin
      next_st.rei_acc = st.rei_acc + rei_inc;
      next_st.bip_acc = st.bip_acc + bip_inc;
    end

    // Label stability tracking per multiframe
    if (i_ovh.mf_valid)
    begin
      next_st.prev_label = rx_label;
      if (rx_label != st.prev_label)
      begin
        next_st.same_run = 3'h1;
        if (st.unstable_cnt != UNSTABLE_LIMIT)
          next_st.unstable_cnt = st.unstable_cnt + 3'h1;
      end
      else if (st.same_run != UNSTABLE_LIMIT)
        next_st.same_run = st.same_run + 3'h1;
      if (next_st.same_run == UNSTABLE_LIMIT)
        next_st.unstable_cnt = 3'h0;
    end
    if (next_st.unstable_cnt == UNSTABLE_LIMIT)
      next_st.unstable = 1'b1;
    else if (next_st.unstable_cnt == 3'h0)
      next_st.unstable = 1'b0;

    next_mismatch = tu3 ? (accepted_label != st.exp_label)
                        : (accepted_label[2:0] != st.exp_label[2:0]);
    next_st.mismatch = next_mismatch;

    // Defect view: V5 defect bit, or extended code when selected
    defect_view = ext_sel ? erdi_f : {2'b00, rdi_f};
    next_st.prev_defect_view = defect_view;
    next_st.prev_rfi = rfi_f;
    next_st.prev_accepted = accepted_label;

    ev_defect = cfg_live && st.group_cfg[GC_REMOTE_DEFECT_IE]
                && (defect_view != st.prev_defect_view);
    ev_failure = cfg_live && !ext_sel && !tu3 && st.group_cfg[GC_REMOTE_FAILURE_IE]
                 && (rfi_f != st.prev_rfi);
    ev_change = cfg_live && st.group_cfg[GC_LABEL_CHANGE_IE]
                && (accepted_label != st.prev_accepted);
    ev_mismatch = cfg_live && st.group_cfg[GC_LABEL_MISMATCH_IE]
                  && (next_mismatch != st.mismatch);
    ev_unstable = cfg_live && st.group_cfg[GC_LABEL_UNSTABLE_IE]
                  && (next_st.unstable != st.unstable);
    next_st.irq = ev_defect || ev_failure || ev_change || ev_mismatch || ev_unstable;

    next_st.pdi = st.cfg_alarm[0] || pd_match_f;

    if (st.cfg_alarm[CA_TERMINATE - CA_PAYLOAD_FORCE])
      next_st.ais = i_alarm.global_ais;
    else
      next_st.ais = i_alarm.lop || i_alarm.lom;

    next_st.trib_type = decode_type(st.group_cfg[GC_TYPE_LSB +: 2]);
    next_st.active = {1'b0, st.group_cfg[GC_TYPE_LSB +: 2]} + 3'h1;

    // Read data stands only in the cycle after the strobe
    next_st.rd_data = '0;
    if (i_req.rd)
    begin
      case (i_req.addr)
        OFS_BIP_LOW: next_st.rd_data = st.bip_rd[7:0];
        OFS_BIP_HIGH: next_st.rd_data = st.bip_rd[15:8];
        OFS_REI_LOW: next_st.rd_data = st.rei_rd[7:0];
        OFS_REI_HIGH: next_st.rd_data = st.rei_rd[15:8];
        OFS_GROUP_CFG: next_st.rd_data = st.group_cfg;
        OFS_CFG_ALARM: next_st.rd_data = {st.cfg_alarm, st.unstable, st.mismatch,
                                          ext_sel ? erdi_f : {1'b0, rfi_f, rdi_f}};
        OFS_MON_CTRL: next_st.rd_data = st.mon_ctrl;
        OFS_EXP_LABEL: next_st.rd_data = st.exp_label;
        OFS_ACC_LABEL: next_st.rd_data = accepted_label;
        default: next_st.rd_data = '0;
      endcase
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      st <= '0;
      st.group_cfg <= GROUP_CFG_RESET;
      st.cfg_alarm <= CFG_ALARM_RESET;
      st.mon_ctrl <= MON_CTRL_RESET;
      st.trib_type <= TRIB_TU11;
      st.active <= 3'h4;
    end
    else
      st <= next_st;
  end

  assign o_rd_data = st.rd_data;
  assign o_irq = st.irq;
  assign o_payload_defect_output = st.pdi;
  assign o_ais_insert = st.ais;
  assign o_trib_type = st.trib_type;
  assign o_active_tributaries = st.active;

endmodule // tributary_path_overhead_monitor
